// *** dv/supply_comparator_model.sv ***
// supply comparator model: turns a coarse supply level into trip outputs
`timescale 1ns/1ns
module supply_comparator_model (
  input  wire logic [1:0] supply_level,
  input  wire logic       trip_level_select,
  output logic            cmp_below_falling,
  output logic            cmp_above_rising
);
  // levels: 0 under low falling, 1 low hysteresis, 2 above low rising,
  // 3 above high rising; the high pair needs level 3 to read as healthy
  always_comb begin
    if (trip_level_select) begin
      cmp_below_falling = (supply_level != 2'h3);
      cmp_above_rising  = (supply_level == 2'h3);
    end else begin
      cmp_below_falling = (supply_level == 2'h0);
      cmp_above_rising  = (supply_level >= 2'h2);
    end
  end
endmodule : supply_comparator_model

// *** dv/supply_monitor_reset_control_props.sv ***
// checker: port-level assertions for the supply monitor
`timescale 1ns/1ns
module supply_monitor_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cmp_below_falling,
  input wire logic cmp_above_rising,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic trip_level_select,
  input wire logic reset_request,
  input wire logic mode_wakeup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_low_power_hold;
    reset_request && (wait_mode || stop_mode) ##1
    reset_request && (wait_mode || stop_mode);
  endsequence
  AST_APB_ANSWER: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  AST_APB_ONE_CYCLE: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
  AST_APB_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RST_CAUSE: assert property ($rose(reset_request) |->
    $past(cmp_below_falling, 2) || $past(cmp_below_falling, 3)
    || $past(cmp_below_falling, 4)) else $error("reset without low supply");
  AST_RST_HOLD: assert property (reset_request &&
    !$past(cmp_above_rising, 2) && !$past(cmp_above_rising, 3)
    |=> reset_request) else $error("reset released early");
  AST_WAKE_QUAL: assert property (mode_wakeup |-> reset_request)
    else $error("wakeup without reset");
  AST_WAKE_CAUSE: assert property (s_low_power_hold |-> mode_wakeup)
    else $error("reset did not wake");
  // config lands at the access edge, the output copy one edge later
  AST_SEL_WRITE: assert property ($changed(trip_level_select) |->
    $past(pwrite, 2) && $past(penable, 2)) else $error("select moved alone");
endmodule : supply_monitor_props
bind supply_monitor_reset_control supply_monitor_props u_props (
  .clk, .arst_n, .psel, .penable, .pwrite, .pready, .pslverr,
  .cmp_below_falling, .cmp_above_rising, .stop_mode, .wait_mode,
  .trip_level_select, .reset_request, .mode_wakeup);

// *** dv/supply_monitor_reset_control_tb.sv ***
// testbench: register and supply scenarios for the supply monitor
`timescale 1ns/1ns
module supply_monitor_reset_control_tb;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        below, above, stop_mode, wait_mode, pwr_on, sel, rst_req;
  logic        wake, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  supply;
  int          n_errors, total_checks, cyc;
  supply_monitor_reset_control u_dut (.clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .cmp_below_falling(below), .cmp_above_rising(above), .stop_mode,
    .wait_mode, .monitor_power_on(pwr_on), .trip_level_select(sel),
    .reset_request(rst_req), .mode_wakeup(wake), .irq);
  supply_comparator_model u_cmp (.supply_level(supply),
    .trip_level_select(sel), .cmp_below_falling(below),
    .cmp_above_rising(above));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // =====================================================
  // tasks
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // bounded wait keeps a silent slave from hanging the run
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error t=%0t apb timeout got=%h exp=%h", $time, pready, 1'b1);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic lvl(input logic [1:0] s);
    supply <= s;
    repeat (8) @(posedge clk);
  endtask : lvl
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  // =====================================================
  // scenarios
  initial begin
    {arst_n, psel, penable, pwrite, stop_mode, wait_mode} = 6'h0;
    paddr = 12'h0; pwdata = 32'h0; supply = 2'h2;
    n_errors = 0; total_checks = 0; cyc = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(pwr_on, 32'h1); chk(sel, 32'h0);
    rd(12'h004, 32'h0);
    rd(12'h010, 32'h0); chk(err, 32'h1);
    lvl(2'h0); chk(rst_req, 32'h1); rd(12'h000, 32'h1);
    rd(12'h008, 32'h1); chk(irq, 32'h0);
    apb(1'b1, 12'h00C, 32'h3); chk(irq, 32'h1);
    lvl(2'h1); chk(rst_req, 32'h1); rd(12'h000, 32'h1);
    apb(1'b1, 12'h000, 32'h0); rd(12'h000, 32'h1);
    lvl(2'h2); chk(rst_req, 32'h0); rd(12'h000, 32'h0);
    rd(12'h008, 32'h3);
    apb(1'b1, 12'h008, 32'h3); rd(12'h008, 32'h0); chk(irq, 32'h0);
    apb(1'b1, 12'h004, 32'h2); lvl(2'h0);
    chk(rst_req, 32'h0); rd(12'h000, 32'h1); lvl(2'h2);
    apb(1'b1, 12'h004, 32'h1); chk(pwr_on, 32'h0); lvl(2'h0);
    chk(rst_req, 32'h0); rd(12'h000, 32'h0); lvl(2'h2);
    apb(1'b1, 12'h004, 32'h0); stop_mode <= 1'b1; lvl(2'h2);
    chk(pwr_on, 32'h0);
    apb(1'b1, 12'h004, 32'h4); chk(pwr_on, 32'h1); lvl(2'h0);
    chk(rst_req, 32'h1); chk(wake, 32'h1); lvl(2'h2);
    stop_mode <= 1'b0; apb(1'b1, 12'h004, 32'h0); wait_mode <= 1'b1;
    lvl(2'h0); chk(wake, 32'h1); lvl(2'h2);
    wait_mode <= 1'b0; apb(1'b1, 12'h004, 32'h8); lvl(2'h2);
    chk(sel, 32'h1); chk(rst_req, 32'h1);
    lvl(2'h3); chk(rst_req, 32'h0);
    final_report();
  end
endmodule : supply_monitor_reset_control_tb

// *** verilog/supply_monitor_pkg.sv ***
// package: register map, field layout and constants for the supply monitor
package supply_monitor_pkg;

  // =====================================================
  // register byte offsets
  localparam logic [11:0] status_offset = 12'h000;
  localparam logic [11:0] config_offset = 12'h004;
  localparam logic [11:0] irq_status_offset = 12'h008;
  localparam logic [11:0] irq_mask_offset = 12'h00C;

  // =====================================================
  // field positions of the configuration word
  localparam int cfg_power_disable_bit = 0;
  localparam int cfg_reset_disable_bit = 1;
  localparam int cfg_stop_alive_bit = 2;
  localparam int cfg_level_select_bit = 3;
  // field position of the status register
  localparam int status_low_flag_bit = 0;

  // =====================================================
  // reset values: monitor on, resets on, 3-V trip pair
  localparam logic [3:0] config_reset = 4'h0;
  localparam logic [1:0] irq_mask_reset = 2'h0;

  // event bits of the interrupt status register
  localparam int ev_fall_bit = 0;
  localparam int ev_rise_bit = 1;

  // =====================================================
  // synchroniser depth
  localparam int sync_stages = 2;

  typedef struct packed {
    logic level_select;
    logic stop_alive;
    logic reset_disable;
    logic power_disable;
  } monitor_config_t;

  typedef struct packed {
    logic below_falling;
    logic above_rising;
  } comparator_t;

  typedef enum logic [1:0] {
    st_off     = 2'b00,
    st_normal  = 2'b01,
    st_reset   = 2'b11
  } monitor_state_t;

endpackage : supply_monitor_pkg

// *** verilog/supply_monitor_reset_control.sv ***
// supply monitor control: option bits, status flag and reset request
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module supply_monitor_reset_control
  import supply_monitor_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_below_falling,
  input  wire logic        cmp_above_rising,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  output logic             monitor_power_on,
  output logic             trip_level_select,
  output logic             reset_request,
  output logic             mode_wakeup,
  output logic             irq
);

  // =====================================================
  // registers
  monitor_config_t cfg;
  comparator_t     cmp_meta;
  comparator_t     cmp_sync;
  logic            supply_low_flag;
  monitor_state_t  state;
  monitor_state_t  next_state;
  logic [1:0]      irq_status;
  logic [1:0]      irq_mask;
  logic            active;
  logic            fall_event;
  logic            rise_event;
  logic            access;
  logic            wr;

  assign access = psel && penable;
  assign wr     = access && pwrite;

  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  // =====================================================
  // comparator synchroniser; first stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_meta <= '0;
      cmp_sync <= '0;
    end else begin
      cmp_meta <= '{below_falling: cmp_below_falling,
                    above_rising:  cmp_above_rising};
      cmp_sync <= cmp_meta;
    end
  end

  // =====================================================
  // configuration word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg <= monitor_config_t'(config_reset);
    end else if (wr && hit(paddr, config_offset) && pstrb[0]) begin
      cfg <= monitor_config_t'(pwdata[3:0]);
    end
  end

  // =====================================================
  // monitor activity by power mode
  always_comb begin
    active = !cfg.power_disable;
    if (stop_mode) begin
      active = !cfg.power_disable && cfg.stop_alive;
    end
  end

  // =====================================================
  // supply low flag with hysteresis
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_low_flag <= 1'b0;
    end else if (active) begin
      if (cmp_sync.below_falling) begin
        supply_low_flag <= 1'b1;
      end else if (cmp_sync.above_rising) begin
        supply_low_flag <= 1'b0;
      end
    end
  end

  // =====================================================
  // reset request state machine
  always_comb begin
    next_state = state;
    unique case (state)
      st_off: begin
        if (active) begin
          next_state = st_normal;
        end
      end
      st_normal: begin
        if (!active) begin
          next_state = st_off;
        // a 5-V select with supply not yet above the 5-V rising level
        // shows as below-falling on the reselected comparator
        end else if (!cfg.reset_disable && cmp_sync.below_falling) begin
          next_state = st_reset;
        end
      end
      st_reset: begin
        // held through disable writes so a glitch cannot drop reset
        if (cmp_sync.above_rising) begin
          next_state = st_normal;
        end
      end
      default: next_state = st_off;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= st_off;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reset_request     <= 1'b0;
      mode_wakeup       <= 1'b0;
      monitor_power_on  <= 1'b1;
      trip_level_select <= 1'b0;
    end else begin
      reset_request     <= (next_state == st_reset);
      mode_wakeup       <= (next_state == st_reset) &&
                           (wait_mode || stop_mode);
      monitor_power_on  <= active;
      trip_level_select <= cfg.level_select;
    end
  end

  // =====================================================
  // events for software; a sticky set beats a same-cycle clear
  assign fall_event = active && cmp_sync.below_falling && !supply_low_flag;
  assign rise_event = active && cmp_sync.above_rising && supply_low_flag;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == ev_fall_bit && fall_event) ||
            (i == ev_rise_bit && rise_event)) begin
          irq_status[i] <= 1'b1;
        end else if (wr && hit(paddr, irq_status_offset) && pstrb[0] &&
                     pwdata[i]) begin
          irq_status[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask <= irq_mask_reset;
    end else if (wr && hit(paddr, irq_mask_offset) && pstrb[0]) begin
      irq_mask <= pwdata[1:0];
    end
  end

  // wrapper notification only; the monitor core raises no request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // =====================================================
  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (hit(paddr, status_offset)) begin
          prdata[status_low_flag_bit] <= supply_low_flag;
        end else if (hit(paddr, config_offset)) begin
          prdata[3:0] <= cfg;
        end else if (hit(paddr, irq_status_offset)) begin
          prdata[1:0] <= irq_status;
        end else if (hit(paddr, irq_mask_offset)) begin
          prdata[1:0] <= irq_mask;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule : supply_monitor_reset_control
